/* include/ahsf_pkg.sv */
// Package of offsets, field positions and reset values for the air hub status flag bank
package ahsf_pkg;

	// ----------------------------------------------------------------
	// Register word indices (one aligned 32-bit word each)
	// ----------------------------------------------------------------
	// Offsets are not all multiples of four, so each is used as a word index
	localparam logic [7:0] IDX_MEAS_STATUS   = 8'h14; // Measurement status byte
	localparam logic [7:0] IDX_DIAG_WORD     = 8'h18; // Regulator diagnostic word
	localparam logic [7:0] IDX_HUB_SHORT     = 8'h1a; // Hub short status byte
	localparam logic [7:0] IDX_REG_QUALITY   = 8'h1b; // Regulator port quality byte
	localparam logic [7:0] IDX_AUX_QUALITY   = 8'h1c; // Aux port quality byte
	localparam int         ADDR_W            = 10;    // Byte address width, index times four

	// ----------------------------------------------------------------
	// Diagnostic word bit positions
	// ----------------------------------------------------------------
	localparam int DG_SETTLED    = 0;  // Pressure within band of target
	localparam int DG_ENERGIZE   = 3;  // Energized time reached limit
	localparam int DG_RESIDUAL   = 4;  // Residual pressure at zero clear
	localparam int DG_TARGET_OVR = 5;  // Target above limit
	localparam int DG_UNDER      = 6;  // Pressure under range
	localparam int DG_OVER       = 7;  // Pressure over range
	localparam int DG_VOLT_LOW   = 8;  // Supply voltage low
	localparam int DG_VOLT_HIGH  = 9;  // Supply voltage high
	localparam int DG_ALARM      = 10; // OR of bits 4..9
	localparam int DG_LINK_ERR   = 11; // Internal link fault
	localparam int DG_VALVE_ERR  = 12; // Built-in valve fault
	localparam int DG_SYS_ERR    = 13; // Internal system fault
	localparam int DG_NVM_ERR    = 14; // Nonvolatile storage fault
	localparam int DG_ERROR      = 15; // OR of bits 11..14

	// ----------------------------------------------------------------
	// Hub short byte and per-port quality byte bit positions
	// ----------------------------------------------------------------
	localparam int HB_SUPPLY_SHORT = 0; // Port power or sensor_supply short
	localparam int HB_LINK_UP      = 1; // Port link state
	localparam int HB_VALVE_SHORT  = 2; // valve_supply short
	localparam int PQ_DEVICE_IDENTITY_MISMATCH  = 0; // device_identity_mismatch
	localparam int PQ_MAP_OVERSIZE = 1; // Process data length exceeds map
	localparam int PQ_SUPPLY_SHORT = 2; // supply_line_short
	localparam int PQ_SIGNAL_SHORT = 3; // signal_line_short
	localparam int PQ_BACKUP_VALID = 4; // backup_valid_flag
	localparam int PQ_LINK_UP      = 5; // link_up_flag
	localparam int PQ_EVENT        = 6; // pending_event_flag
	localparam int PQ_INPUT_VALID  = 7; // input_valid_flag

	// ----------------------------------------------------------------
	// Reset values and settle band
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE    = 8'h00; // All flags clear after reset
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [31:0] RD_UNMAPPED = 32'h00000000; // Unmapped reads return zero
	localparam int          BAND_PCT    = 10;    // Settle band, percent of target

endpackage

/* rtl/ahsf_status_flags.sv */
// Air hub status flag bank: flag assembly plus classic Wishbone read-only slave
//
// Behaviour
// - Bit 0 set when pressure within 10% target
// - Bit 3 set when energized time reaches limit
// - Bit 4 flags residual pressure at zero clear
// - Bit 5 set when target exceeds limit
// - Bit 6 set when pressure under range
// - Bit 7 set when pressure over range
// - Bit 8 set while supply voltage low
// - Bit 9 set while supply voltage high
// - Bit 10 is OR of bits 4..9
// - Bits 11..13 link, valve, system faults
// - Bit 14 set on nonvolatile storage fault
// - Bit 15 is OR of bits 11..14
// - Hub bit 0 set on supply short
// - Hub bit 1, port bit 5 link state
// - Hub bit 2 valve short; 3..7 reserved
// - Port bit 0 set on identity mismatch
// - Port bit 1 set on oversize process data
// - Port bits 2,3 supply and signal shorts
// - Port bit 4 set when backup valid
// - Port bit 6 set while event pending
// - Port bit 7 set when input valid
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps

module ahsf_status_flags #(
	parameter int PW    = 16, // Pressure value width
	parameter int NPORT = 2   // Port quality bytes: regulator and aux
) (
	input  wire logic              clk_i,            // System clock, 125 MHz
	input  wire logic              rst_i,            // Synchronous reset, active high
	input  wire logic              ce_i,             // Clock enable, freezes all state when low
	// Wishbone classic slave
	input  wire logic              cyc_i,            // Bus cycle
	input  wire logic              stb_i,            // Strobe
	input  wire logic              we_i,             // Write enable (writes ignored)
	input  wire logic [ahsf_pkg::ADDR_W-1:0] adr_i,  // Byte address
	input  wire logic [3:0]        sel_i,            // Byte selects
	input  wire logic [31:0]       dat_i,            // Write data (ignored)
	output logic      [31:0]       dat_o,            // Read data
	output logic                   ack_o,            // Acknowledge
	// Measurement status byte source
	input  wire logic [7:0]        meas_status_i,    // Measurement status flags
	// Regulator pressure conditions
	input  wire logic [PW-1:0]     pressure_i,       // Output pressure
	input  wire logic [PW-1:0]     target_i,         // Commanded target
	input  wire logic [PW-1:0]     target_limit_i,   // Permitted target ceiling
	input  wire logic [PW-1:0]     press_low_lim_i,  // Lower pressure limit
	input  wire logic [PW-1:0]     press_high_lim_i, // Upper pressure limit
	input  wire logic [PW-1:0]     residual_lim_i,   // Residual pressure limit
	input  wire logic              zero_clear_i,     // Zero-clear in progress
	input  wire logic              energize_done_i,  // Energized time reached limit
	input  wire logic              volt_low_i,       // Supply voltage below limit
	input  wire logic              volt_high_i,      // Supply voltage above limit
	input  wire logic              link_fault_i,     // Internal link fault
	input  wire logic              valve_fault_i,    // Built-in valve fault
	input  wire logic              system_fault_i,   // Internal system fault
	input  wire logic              nvm_fault_i,      // Nonvolatile storage fault
	// Hub conditions
	input  wire logic              hub_supply_short_i, // Port power or sensor_supply short
	input  wire logic              valve_supply_short_i, // valve_supply short
	// Per-port conditions, one bit per port
	input  wire logic [NPORT-1:0]  device_identity_mismatch_i, // Connected identity differs
	input  wire logic [NPORT-1:0]  map_oversize_i,   // Process data exceeds mapping
	input  wire logic [NPORT-1:0]  supply_line_short_i, // Supply line short
	input  wire logic [NPORT-1:0]  signal_line_short_i, // Signal line short
	input  wire logic [NPORT-1:0]  backup_valid_i,   // parameter_backup data valid
	input  wire logic [NPORT-1:0]  link_up_i,        // Operating or pre-operating
	input  wire logic [NPORT-1:0]  pending_event_i,  // Warning or error pending
	input  wire logic [NPORT-1:0]  input_valid_i,    // Received input data valid
	// Snapshot outputs
	output logic      [15:0]       diag_word_o,      // Diagnostic word
	output logic      [7:0]        hub_short_o       // Hub short status byte
);

	// ----------------------------------------------------------------
	// Flag registers
	// ----------------------------------------------------------------
	logic [7:0]  meas_status;               // Measurement status byte
	logic [15:0] diag_word;                 // Diagnostic word
	logic [7:0]  hub_short;                 // Hub byte
	logic [7:0]  port_quality [NPORT];      // Per-port quality bytes
	logic [15:0] next_diag;                 // Next diagnostic word
	logic [PW+6:0] dev_scaled;              // |p - t| * 100, seven extra bits hold the product
	logic [PW+6:0] band_scaled;             // t * BAND_PCT
	logic [PW-1:0] abs_dev;                 // Absolute deviation

	// ----------------------------------------------------------------
	// Settle band compare
	// ----------------------------------------------------------------
	// Scaled compare avoids a divider: |p-t|*100 <= t*10
	always_comb begin
		abs_dev     = (pressure_i >= target_i) ? pressure_i - target_i : target_i - pressure_i;
		dev_scaled  = (PW+7)'(abs_dev) * (PW+7)'(100);
		band_scaled = (PW+7)'(target_i) * (PW+7)'(ahsf_pkg::BAND_PCT);
	end

	// ----------------------------------------------------------------
	// Diagnostic word composition
	// ----------------------------------------------------------------
	always_comb begin
		next_diag = ahsf_pkg::RST_WORD; // Reserved bits 1 and 2 stay zero
		next_diag[ahsf_pkg::DG_SETTLED]    = (dev_scaled <= band_scaled);
		next_diag[ahsf_pkg::DG_ENERGIZE]   = energize_done_i;
		next_diag[ahsf_pkg::DG_RESIDUAL]   = zero_clear_i && (pressure_i > residual_lim_i);
		next_diag[ahsf_pkg::DG_TARGET_OVR] = target_i > target_limit_i;
		next_diag[ahsf_pkg::DG_UNDER]      = pressure_i < press_low_lim_i;
		next_diag[ahsf_pkg::DG_OVER]       = pressure_i > press_high_lim_i;
		next_diag[ahsf_pkg::DG_VOLT_LOW]   = volt_low_i;
		next_diag[ahsf_pkg::DG_VOLT_HIGH]  = volt_high_i;
		next_diag[ahsf_pkg::DG_ALARM]      = |next_diag[ahsf_pkg::DG_VOLT_HIGH:ahsf_pkg::DG_RESIDUAL];
		next_diag[ahsf_pkg::DG_LINK_ERR]   = link_fault_i;
		next_diag[ahsf_pkg::DG_VALVE_ERR]  = valve_fault_i;
		next_diag[ahsf_pkg::DG_SYS_ERR]    = system_fault_i;
		next_diag[ahsf_pkg::DG_NVM_ERR]    = nvm_fault_i;
		next_diag[ahsf_pkg::DG_ERROR]      = |next_diag[ahsf_pkg::DG_NVM_ERR:ahsf_pkg::DG_LINK_ERR];
	end

	// ----------------------------------------------------------------
	// Flag capture, refreshed every enabled cycle
	// ----------------------------------------------------------------
	// No sticky state: a cleared condition clears its flag next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meas_status <= ahsf_pkg::RST_BYTE;
			diag_word   <= ahsf_pkg::RST_WORD;
			hub_short   <= ahsf_pkg::RST_BYTE;
		end else if (ce_i) begin
			meas_status <= meas_status_i;
			diag_word   <= next_diag;
			hub_short   <= {5'h00, valve_supply_short_i, link_up_i[0], hub_supply_short_i};
		end
	end

	// Per-port quality bytes, port 0 is the regulator port
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				port_quality[p] <= ahsf_pkg::RST_BYTE;
			end else if (ce_i) begin
				port_quality[p] <= {input_valid_i[p], pending_event_i[p], link_up_i[p],
					backup_valid_i[p], signal_line_short_i[p], supply_line_short_i[p],
					map_oversize_i[p], device_identity_mismatch_i[p]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave: read only, one registered ack per request
	// ----------------------------------------------------------------
	logic        req;              // Fresh request this cycle
	logic [7:0]  idx;              // Word index
	logic [31:0] next_rd;          // Decoded read data
	assign req = cyc_i && stb_i && !ack_o;
	assign idx = 8'(adr_i[ahsf_pkg::ADDR_W-1:2]);

	// Read decode; unmapped and reserved bits return zero
	always_comb begin
		next_rd = ahsf_pkg::RD_UNMAPPED;
		unique case (idx)
			ahsf_pkg::IDX_MEAS_STATUS: next_rd = {24'h000000, meas_status};
			ahsf_pkg::IDX_DIAG_WORD:   next_rd = {16'h0000, diag_word};
			ahsf_pkg::IDX_HUB_SHORT:   next_rd = {24'h000000, hub_short};
			ahsf_pkg::IDX_REG_QUALITY: next_rd = {24'h000000, port_quality[0]};
			ahsf_pkg::IDX_AUX_QUALITY: next_rd = (NPORT > 1) ? {24'h000000, port_quality[NPORT-1]} : 32'h00000000;
			default:                   next_rd = ahsf_pkg::RD_UNMAPPED;
		endcase
	end

	// Ack one cycle after request; writes are acked but change nothing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else if (ce_i) begin
			ack_o <= req;
			if (req && !we_i) begin
				dat_o <= next_rd;
			end
		end
	end

	// Snapshot outputs straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag_word_o <= ahsf_pkg::RST_WORD;
			hub_short_o <= ahsf_pkg::RST_BYTE;
		end else if (ce_i) begin
			diag_word_o <= next_diag;
			hub_short_o <= {5'h00, valve_supply_short_i, link_up_i[0], hub_supply_short_i};
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_settled_band: assert property (ce_i && target_i == PW'(1000) && pressure_i == PW'(1101) |=> !diag_word[0])
		else $error("settled flag set outside band");
	a_energize_flag: assert property (ce_i |=> diag_word[3] == $past(energize_done_i))
		else $error("energize flag wrong");
	a_residual_flag: assert property (ce_i && !zero_clear_i |=> !diag_word[4])
		else $error("residual flag outside zero clear");
	a_target_over: assert property (ce_i |=> diag_word[5] == ($past(target_i) > $past(target_limit_i)))
		else $error("target over flag wrong");
	a_under_range: assert property (ce_i |=> diag_word[6] == ($past(pressure_i) < $past(press_low_lim_i)))
		else $error("under range flag wrong");
	a_over_range: assert property (ce_i |=> diag_word[7] == ($past(pressure_i) > $past(press_high_lim_i)))
		else $error("over range flag wrong");
	a_volt_flags: assert property (ce_i |=> diag_word[9:8] == {$past(volt_high_i), $past(volt_low_i)})
		else $error("voltage flags wrong");
	a_alarm_or: assert property (diag_word[10] == |diag_word[9:4])
		else $error("alarm summary wrong");
	a_error_or: assert property (diag_word[15] == |diag_word[14:11])
		else $error("error summary wrong");
	a_fault_bits: assert property (ce_i |=> diag_word[14:11] ==
		{$past(nvm_fault_i), $past(system_fault_i), $past(valve_fault_i), $past(link_fault_i)})
		else $error("fault bits wrong");
	a_hub_reserved: assert property (hub_short[7:3] == 5'h00 && diag_word[2:1] == 2'h0)
		else $error("reserved bits nonzero");
	a_hub_link: assert property (hub_short[1] == port_quality[0][5])
		else $error("hub link mismatch");
	a_port_flags: assert property (ce_i |=> port_quality[0] == {$past(input_valid_i[0]), $past(pending_event_i[0]),
		$past(link_up_i[0]), $past(backup_valid_i[0]), $past(signal_line_short_i[0]),
		$past(supply_line_short_i[0]), $past(map_oversize_i[0]), $past(device_identity_mismatch_i[0])})
		else $error("port byte wrong");
	a_flag_clears: assert property (ce_i && diag_word[8] && !volt_low_i |=> !diag_word[8])
		else $error("flag did not clear");
	a_bus_ack: assert property (ce_i && req |=> ack_o ##1 !ack_o || !ce_i)
		else $error("ack not one cycle");
	a_write_inert: assert property (ack_o && we_i |-> $stable(dat_o))
		else $error("write altered state");

	c_alarm: cover property (diag_word[10]);
	c_error: cover property (diag_word[15]);
	c_read_diag: cover property (ack_o && !we_i && idx == ahsf_pkg::IDX_DIAG_WORD);
	c_settled: cover property (diag_word[0] && hub_short[1]);

endmodule // ahsf_status_flags

/* test/ahsf_fieldbus_ctl.sv */
// Fieldbus controller model: classic Wishbone master polling the status bank
`timescale 1ns/100ps

module ahsf_fieldbus_ctl (
	input  wire logic        clk_i,  // System clock
	input  wire logic        ack_i,  // Slave acknowledge
	input  wire logic [31:0] dat_i,  // Read data from slave
	output logic             cyc_o,  // Bus cycle
	output logic             stb_o,  // Strobe
	output logic             we_o,   // Write enable
	output logic [9:0]       adr_o,  // Byte address
	output logic [3:0]       sel_o,  // Byte selects
	output logic [31:0]      dat_o   // Write data
);
	// ----------------------------------------------------------------
	// Idle bus at time zero
	// ----------------------------------------------------------------
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 10'h000;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
	end

	// One single cycle; request held until ack is seen at a rising edge or 50 edges pass
	task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		rd = 32'h0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= wr;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= wd;
		for (n = 0; n < 50 && !ok; n++) begin
			@(posedge clk_i);
			if (ack_i === 1'b1) begin
				ok = 1'b1;
				rd = dat_i;
			end
		end
		// Released address and data lines show an inverted pattern; we_o and sel_o keep their stale value
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~wd;
	endtask
endmodule // ahsf_fieldbus_ctl

/* test/tb_top.sv */
// Self-checking bench for the air hub status flag bank
`timescale 1ns/100ps

module tb_top;
	logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, zero_clear_i, energize_done_i;
	logic        volt_low_i, volt_high_i, link_fault_i, valve_fault_i, system_fault_i, nvm_fault_i;
	logic        hub_supply_short_i, valve_supply_short_i;
	logic [9:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o;
	logic [7:0]  meas_status_i, hub_short_o;
	logic [15:0] pressure_i, target_i, target_limit_i, press_low_lim_i, press_high_lim_i, residual_lim_i;
	logic [15:0] diag_word_o;
	logic [1:0]  pin [8];    // Per-port conditions, index is the quality byte bit
	int          bad_count;  // Mismatches
	int          tests_run;  // Comparisons
	// Expected diagnostic words of the condition table
	localparam logic [15:0] EXP [15] = '{16'h0001, 16'h0009, 16'h0501, 16'h0601, 16'h8801, 16'h9001,
		16'ha001, 16'hc001, 16'h0001, 16'h0000, 16'h0440, 16'h0480, 16'h0421, 16'h0001, 16'h0411};

	// ----------------------------------------------------------------
	// Design, bus partner and clock
	// ----------------------------------------------------------------
	ahsf_status_flags dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .meas_status_i, .pressure_i, .target_i, .target_limit_i, .press_low_lim_i, .press_high_lim_i,
		.residual_lim_i, .zero_clear_i, .energize_done_i, .volt_low_i, .volt_high_i, .link_fault_i,
		.valve_fault_i, .system_fault_i, .nvm_fault_i, .hub_supply_short_i, .valve_supply_short_i,
		.device_identity_mismatch_i(pin[0]), .map_oversize_i(pin[1]), .supply_line_short_i(pin[2]),
		.signal_line_short_i(pin[3]), .backup_valid_i(pin[4]), .link_up_i(pin[5]),
		.pending_event_i(pin[6]), .input_valid_i(pin[7]), .diag_word_o, .hub_short_o);
	ahsf_fieldbus_ctl u_ctl (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
		.we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected t=%0t %s got %h exp %h", $time, what, got, exp);
			bad_count++;
		end
	endtask
	// Bus access; a missing ack ends the run
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd, input logic [31:0] e);
		logic [31:0] d;
		bit          ok;
		u_ctl.access(wr, a, wd, d, ok);
		if (!ok) begin
			$display("unexpected t=%0t no ack at %h", $time, a);
			bad_count++;
			wrap_up();
		end
		if (!wr) cmp(d, e, "read data");
	endtask
	// Drive the regulator conditions in one edge: pressure, target, fault flags
	task automatic drive(input logic [15:0] p, input logic [15:0] t, input logic [7:0] f);
		@(posedge clk_i);
		pressure_i      <= p;
		target_i        <= t;
		zero_clear_i    <= f[0];
		energize_done_i <= f[1];
		volt_low_i      <= f[2];
		volt_high_i     <= f[3];
		link_fault_i    <= f[4];
		valve_fault_i   <= f[5];
		system_fault_i  <= f[6];
		nvm_fault_i     <= f[7];
		repeat (2) @(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Bank after reset shows only the settled flag, unmapped word reads zero
	task automatic t_reset;
		repeat (2) @(posedge clk_i);
		#1;
		cmp({16'h0, diag_word_o}, 32'h0001, "diag out after reset");
		bus(1'b0, 10'h060, 32'h0, 32'h0001);
		bus(1'b0, 10'h004, 32'h0, 32'h0);
		$display("test reset done");
	endtask
	// Each condition alone, band edges, then the range, target and residual flags
	task automatic t_diag;
		logic [15:0] p, t;
		for (int i = 0; i < 15; i++) begin
			p = (i == 8) ? 16'd1100 : (i == 9) ? 16'd1101 : (i == 10) ? 16'd50 : (i == 11) ? 16'd6000 : 16'd1000;
			if (i == 12) p = 16'd4001;
			if (i == 14) p = 16'd2001;
			t = (i >= 12 && i != 13) ? p : 16'd1000;
			drive(p, t, (i >= 1 && i <= 7) ? (8'h01 << i) : (i >= 13) ? 8'h01 : 8'h00);
			cmp({16'h0, diag_word_o}, {16'h0, EXP[i]}, "diag out");
			bus(1'b0, 10'h060, 32'h0, {16'h0, EXP[i]});
		end
		$display("test diag done");
	endtask
	// One per-port condition at a time on each port
	task automatic t_ports;
		for (int j = 0; j < 16; j++) begin
			@(posedge clk_i);
			for (int m = 0; m < 8; m++) pin[m] <= (m == j / 2) ? (2'b01 << (j % 2)) : 2'b00;
			repeat (2) @(posedge clk_i);
			bus(1'b0, 10'h06c, 32'h0, (j % 2 == 0) ? (32'h1 << (j / 2)) : 32'h0);
			bus(1'b0, 10'h070, 32'h0, (j % 2 == 1) ? (32'h1 << (j / 2)) : 32'h0);
			cmp({24'h0, hub_short_o}, (j == 10) ? 32'h2 : 32'h0, "hub link");
		end
		$display("test ports done");
	endtask
	// Hub shorts, reserved bits and ignored writes
	task automatic t_hub;
		@(posedge clk_i);
		hub_supply_short_i   <= 1'b1;
		valve_supply_short_i <= 1'b1;
		meas_status_i        <= 8'ha5;
		repeat (2) @(posedge clk_i);
		bus(1'b0, 10'h068, 32'h0, 32'h5);
		cmp({24'h0, hub_short_o}, 32'h5, "hub out");
		bus(1'b1, 10'h068, 32'hffffffff, 32'h0);
		bus(1'b1, 10'h050, 32'hffffffff, 32'h0);
		bus(1'b0, 10'h050, 32'h0, 32'ha5);
		bus(1'b0, 10'h068, 32'h0, 32'h5);
		$display("test hub done");
	endtask
	// Clock enable low freezes the flags
	task automatic t_ce;
		@(posedge clk_i);
		ce_i <= 1'b0;
		drive(16'd1000, 16'd1000, 8'h04);
		cmp({16'h0, diag_word_o}, 32'h0411, "frozen diag");
		@(posedge clk_i);
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		cmp({16'h0, diag_word_o}, 32'h0501, "resumed diag");
		$display("test ce done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		bad_count = 0;
		tests_run = 0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		meas_status_i = 8'h00;
		{zero_clear_i, energize_done_i, volt_low_i, volt_high_i} = 4'h0;
		{link_fault_i, valve_fault_i, system_fault_i, nvm_fault_i} = 4'h0;
		{hub_supply_short_i, valve_supply_short_i} = 2'b00;
		pressure_i = 16'd1000;
		target_i = 16'd1000;
		target_limit_i = 16'd4000;
		press_low_lim_i = 16'd100;
		press_high_lim_i = 16'd5000;
		residual_lim_i = 16'd2000;
		for (int m = 0; m < 8; m++) pin[m] = 2'b00;
		repeat (8) @(posedge clk_i);
		cmp({16'h0, diag_word_o}, 32'h0, "diag out in reset");
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_diag();
		t_ports();
		t_hub();
		t_ce();
		wrap_up();
	end
endmodule // tb_top
